// [core/acps_pkg.sv]
`default_nettype none
package acps_pkg;
  // Clock and start-up timer
  localparam int          CLK_MHZ          = 100;
  localparam int          STARTUP_TIME_US  = 16400;
  localparam int          STARTUP_CYCLES   = STARTUP_TIME_US * CLK_MHZ;
  localparam int          TMR_W            = 24;
  // Synchronised pin vector layout
  localparam int          SI_PWR_N         = 0;
  localparam int          SI_MUTE          = 1;
  localparam int          SI_ROLE          = 2;
  localparam int          SI_SYNC          = 3;
  localparam int          SI_N             = 4;
  localparam logic [3:0]  SI_RST           = 4'h0;
  // Register map, byte addresses
  localparam int          ADDR_W           = 8;
  localparam logic [7:0]  OFS_CTRL         = 8'h00;
  localparam logic [7:0]  OFS_OSC_HALF     = 8'h04;
  localparam logic [7:0]  OFS_STATUS       = 8'h08;
  localparam logic [7:0]  OFS_IRQ_STATUS   = 8'h0c;
  localparam logic [7:0]  OFS_IRQ_CLEAR    = 8'h10;
  localparam logic [7:0]  OFS_IRQ_ENABLE   = 8'h14;
  localparam logic [7:0]  OFS_SYNC_PERIOD  = 8'h18;
  // Control fields and reset values
  localparam int          CTRL_SW_MUTE     = 0;
  localparam int          OSC_W            = 16;
  localparam logic [15:0] OSC_HALF_RST     = 16'h00c8;
  // Status fields
  localparam int          ST_STATE_LO      = 0;
  localparam int          ST_OUT_EN        = 2;
  localparam int          ST_FAULT         = 3;
  localparam int          ST_THERM         = 4;
  localparam int          ST_ROLE          = 5;
  localparam int          ST_LOW_PWR       = 6;
  // Interrupt events
  localparam int          IRQ_SHORT        = 0;
  localparam int          IRQ_THERM_TRIP   = 1;
  localparam int          IRQ_THERM_CLR    = 2;
  localparam int          IRQ_RUN          = 3;
  localparam int          IRQ_N            = 4;
  // AXI responses
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  typedef enum logic [1:0] {
    ACPS_OFF  = 2'h0,
    ACPS_BIAS = 2'h1,
    ACPS_WAIT = 2'h3,
    ACPS_RUN  = 2'h2
  } acps_state_t;
endpackage
`default_nettype wire

// [core/acps_pins_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface acps_pins_if;
  import acps_pkg::*;
  logic [SI_N-1:0] lvl;
  modport src (output lvl);
  modport dst (input lvl);
endinterface
`default_nettype wire

// [core/acps_pin_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module acps_pin_sync (
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire logic                  clk_en,
  input  wire logic [acps_pkg::SI_N-1:0] raw,
  acps_pins_if.src                   pins
);
  import acps_pkg::*;

  logic [SI_N-1:0] meta_ff;
  logic [SI_N-1:0] lvl_ff;

  genvar i;
  generate
    for (i = 0; i < SI_N; i++) begin : g_bit
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_ff[i] <= SI_RST[i];
          lvl_ff[i]  <= SI_RST[i];
        end else if (clk_en) begin
          meta_ff[i] <= raw[i];
          lvl_ff[i]  <= meta_ff[i];
        end
      end
    end
  endgenerate

  assign pins.lvl = lvl_ff;
endmodule
`default_nettype wire

// [core/acps_sequencer.sv]
// Our own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module acps_sequencer #(
  parameter int STARTUP_CYC = acps_pkg::STARTUP_CYCLES
) (
  input  wire logic                      sys_clk,
  input  wire logic                      rst_n,
  input  wire logic                      clk_en,
  input  wire logic [acps_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [acps_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      pwr_off_n,
  input  wire logic                      out_disable,
  input  wire logic                      timing_role_select,
  input  wire logic                      sync_in,
  output logic                           sync_out,
  output logic                           sync_oe,
  input  wire logic                      bias_ref_ok,
  input  wire logic                      short_det,
  input  wire logic                      temp_trip,
  input  wire logic                      temp_cooled,
  output logic                           out_enable,
  output logic                           low_power,
  output logic                           short_alarm,
  output logic                           switch_clk,
  output logic                           irq
);
  import acps_pkg::*;

  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(STARTUP_CYC - 1);

  acps_pins_if pins ();

  acps_pin_sync u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .raw     ({sync_in, timing_role_select, out_disable, pwr_off_n}),
    .pins    (pins.src)
  );

  logic              pwr_on_s;
  logic              mute_s;
  logic              master_s;
  logic              sync_s;
  logic              mute_eff;
  acps_state_t       state_ff;
  acps_state_t       nxt_state;
  logic [TMR_W-1:0]  tmr_ff;
  logic              fault_ff;
  logic              therm_ff;
  logic              out_en_ff;
  logic              sw_mute_ff;
  logic [OSC_W-1:0]  osc_half_ff;
  logic [OSC_W-1:0]  osc_cnt_ff;
  logic              sw_clk_ff;
  logic              sync_d_ff;
  logic              sync_rise;
  logic [OSC_W-1:0]  per_cnt_ff;
  logic [OSC_W-1:0]  sync_per_ff;
  logic [IRQ_N-1:0]  irq_stat_ff;
  logic [IRQ_N-1:0]  irq_en_ff;
  logic [IRQ_N-1:0]  irq_evt;
  logic [IRQ_N-1:0]  irq_clr;
  logic              aw_got_ff;
  logic              w_got_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0]       wdata_ff;
  logic [3:0]        wstrb_ff;
  logic              wr_go;
  logic              wr_hit;
  logic [31:0]       rd_val;
  logic              rd_hit;

  assign pwr_on_s = pins.lvl[SI_PWR_N];
  assign mute_s   = pins.lvl[SI_MUTE];
  assign master_s = pins.lvl[SI_ROLE];
  assign sync_s   = pins.lvl[SI_SYNC];
  assign mute_eff = mute_s | sw_mute_ff;

  // Start-up sequencer; shutdown by pin or thermal trip restarts the sequence
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ACPS_OFF: begin
        if (pwr_on_s && !therm_ff) begin
          nxt_state = ACPS_BIAS;
        end
      end
      ACPS_BIAS: begin
        if (bias_ref_ok) begin
          nxt_state = ACPS_WAIT;
        end
      end
      ACPS_WAIT: begin
        if (tmr_ff == TMR_LAST) begin
          nxt_state = ACPS_RUN;
        end
      end
      ACPS_RUN: begin
        nxt_state = ACPS_RUN;
      end
    endcase
    if (!pwr_on_s || therm_ff) begin
      nxt_state = ACPS_OFF;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ACPS_OFF;
    end else if (clk_en) begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_ff <= '0;
    end else if (clk_en) begin
      if (state_ff == ACPS_WAIT && nxt_state == ACPS_WAIT) begin
        tmr_ff <= tmr_ff + 1'b1;
      end else begin
        tmr_ff <= '0;
      end
    end
  end

  // Latched short fault: set wins over the clear by mute or power-off
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_ff <= 1'b0;
    end else if (clk_en) begin
      if (short_det && out_en_ff) begin
        fault_ff <= 1'b1;
      end else if (mute_s || !pwr_on_s) begin
        fault_ff <= 1'b0;
      end
    end
  end

  // Thermal hysteresis from the two comparator levels
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      therm_ff <= 1'b0;
    end else if (clk_en) begin
      if (temp_trip) begin
        therm_ff <= 1'b1;
      end else if (temp_cooled) begin
        therm_ff <= 1'b0;
      end
    end
  end

  // Output drive; the same-cycle short term cuts drive at the same edge that sets the latch
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_en_ff <= 1'b0;
    end else if (clk_en) begin
      out_en_ff <= (nxt_state == ACPS_RUN) && !mute_eff && !fault_ff
                   && !(short_det && out_en_ff);
    end
  end

  // Switching clock: divider in master role, follows sync pin in slave role
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt_ff <= '0;
      sw_clk_ff  <= 1'b0;
    end else if (clk_en) begin
      if (master_s) begin
        if (osc_cnt_ff >= osc_half_ff - 1'b1) begin
          osc_cnt_ff <= '0;
          sw_clk_ff  <= ~sw_clk_ff;
        end else begin
          osc_cnt_ff <= osc_cnt_ff + 1'b1;
        end
      end else begin
        osc_cnt_ff <= '0;
        sw_clk_ff  <= sync_s;
      end
    end
  end

  // Incoming sync period, in system clocks
  assign sync_rise = sync_s && !sync_d_ff;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_d_ff   <= 1'b0;
      per_cnt_ff  <= '0;
      sync_per_ff <= '0;
    end else if (clk_en) begin
      sync_d_ff <= sync_s;
      if (master_s) begin
        per_cnt_ff <= '0;
      end else if (sync_rise) begin
        sync_per_ff <= per_cnt_ff + 1'b1;
        per_cnt_ff  <= '0;
      end else if (per_cnt_ff != '1) begin
        per_cnt_ff <= per_cnt_ff + 1'b1;
      end
    end
  end

  assign sync_out    = sw_clk_ff;
  assign sync_oe     = master_s;
  assign switch_clk  = sw_clk_ff;
  assign out_enable  = out_en_ff;
  assign short_alarm = fault_ff;
  assign low_power   = (state_ff == ACPS_OFF);

  // Interrupt events
  assign irq_evt[IRQ_SHORT]      = short_det && out_en_ff;
  assign irq_evt[IRQ_THERM_TRIP] = temp_trip && !therm_ff;
  assign irq_evt[IRQ_THERM_CLR]  = therm_ff && !temp_trip && temp_cooled;
  assign irq_evt[IRQ_RUN]        = (state_ff == ACPS_WAIT) && (nxt_state == ACPS_RUN);
  assign irq_clr = (wr_go && awaddr_ff == OFS_IRQ_CLEAR && wstrb_ff[0])
                   ? wdata_ff[IRQ_N-1:0] : '0;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_ff <= '0;
    end else if (clk_en) begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_evt;
    end
  end

  assign irq = |(irq_stat_ff & irq_en_ff);

  // AXI4-Lite write: address and data taken in either order
  assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_ff && !s_axi_bvalid;
  assign wr_go         = aw_got_ff && w_got_ff && !s_axi_bvalid;
  assign wr_hit        = (awaddr_ff == OFS_CTRL) || (awaddr_ff == OFS_OSC_HALF)
                         || (awaddr_ff == OFS_IRQ_CLEAR) || (awaddr_ff == OFS_IRQ_ENABLE);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_ff    <= 1'b0;
      w_got_ff     <= 1'b0;
      awaddr_ff    <= '0;
      wdata_ff     <= '0;
      wstrb_ff     <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= {s_axi_awaddr[ADDR_W-1:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_ff    <= 1'b0;
        w_got_ff     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_mute_ff  <= 1'b0;
      osc_half_ff <= OSC_HALF_RST;
      irq_en_ff   <= '0;
    end else if (clk_en && wr_go) begin
      if (awaddr_ff == OFS_CTRL && wstrb_ff[0]) begin
        sw_mute_ff <= wdata_ff[CTRL_SW_MUTE];
      end
      if (awaddr_ff == OFS_OSC_HALF) begin
        if (wstrb_ff[0]) begin
          osc_half_ff[7:0] <= wdata_ff[7:0];
        end
        if (wstrb_ff[1]) begin
          osc_half_ff[15:8] <= wdata_ff[15:8];
        end
      end
      if (awaddr_ff == OFS_IRQ_ENABLE && wstrb_ff[0]) begin
        irq_en_ff <= wdata_ff[IRQ_N-1:0];
      end
    end
  end

  // AXI4-Lite read
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_val = '0;
    rd_hit = 1'b1;
    unique case ({s_axi_araddr[ADDR_W-1:2], 2'h0})
      OFS_CTRL:        rd_val[CTRL_SW_MUTE] = sw_mute_ff;
      OFS_OSC_HALF:    rd_val[OSC_W-1:0] = osc_half_ff;
      OFS_STATUS: begin
        rd_val[ST_STATE_LO +: 2] = state_ff;
        rd_val[ST_OUT_EN]        = out_en_ff;
        rd_val[ST_FAULT]         = fault_ff;
        rd_val[ST_THERM]         = therm_ff;
        rd_val[ST_ROLE]          = master_s;
        rd_val[ST_LOW_PWR]       = low_power;
      end
      OFS_IRQ_STATUS:  rd_val[IRQ_N-1:0] = irq_stat_ff;
      OFS_IRQ_CLEAR:   rd_val = '0;
      OFS_IRQ_ENABLE:  rd_val[IRQ_N-1:0] = irq_en_ff;
      OFS_SYNC_PERIOD: rd_val[OSC_W-1:0] = sync_per_ff;
      default:         rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_val;
        s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [verification/acps_sequencer_properties.sv]
`timescale 1ns/1ns
`default_nettype none
module acps_seq_props #(
  parameter int STARTUP_CYC = 20
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic pwr_off_n,
  input wire logic out_disable,
  input wire logic timing_role_select,
  input wire logic short_det,
  input wire logic temp_trip,
  input wire logic out_enable,
  input wire logic low_power,
  input wire logic short_alarm,
  input wire logic sync_oe,
  input wire logic irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] up_ff;
  // Cycles spent since leaving the off state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) up_ff <= 32'h0;
    else if (low_power) up_ff <= 32'h0;
    else if (clk_en) up_ff <= up_ff + 32'h1;
  end
  a_short_cuts_drive: assert property (
    short_det && out_enable && clk_en |=> !out_enable && short_alarm) else $error("short kept");
  a_mute_stops_out: assert property (
    (out_disable && clk_en)[*5] |-> !out_enable) else $error("mute ignored");
  a_mute_clears_alarm: assert property (
    (out_disable && clk_en)[*5] |-> !short_alarm) else $error("alarm not cleared");
  a_off_low_power: assert property (
    (!pwr_off_n && clk_en)[*5] |-> low_power && !out_enable) else $error("off ignored");
  a_fault_sticky: assert property (
    (pwr_off_n && !out_disable && clk_en)[*3] ##0 short_alarm |=> short_alarm)
    else $error("fault lost");
  a_startup_wait: assert property (
    $rose(out_enable) |-> up_ff >= STARTUP_CYC) else $error("early start");
  a_therm_shut: assert property (
    temp_trip && clk_en ##1 clk_en |=> low_power && !out_enable) else $error("no thermal stop");
  a_master_drives: assert property (
    (timing_role_select && clk_en)[*4] |-> sync_oe) else $error("sync not driven");
  c_run: cover property ($rose(out_enable));
  c_alarm: cover property ($rose(short_alarm));
  c_irq: cover property ($rose(irq));
endmodule
bind acps_sequencer acps_seq_props #(.STARTUP_CYC(STARTUP_CYC)) u_props (.sys_clk, .rst_n,
  .clk_en, .pwr_off_n, .out_disable, .timing_role_select, .short_det, .temp_trip, .out_enable,
  .low_power, .short_alarm, .sync_oe, .irq);
`default_nettype wire

// [verification/acps_ctl_model.sv]
`timescale 1ns/1ns
`default_nettype none
module acps_ctl_model #(
  parameter int HALF = 200
) (
  input  wire logic sys_clk,
  input  wire logic loop_en,
  input  wire logic ext_mute,
  input  wire logic short_alarm,
  input  wire logic sync_oe,
  input  wire logic sync_out,
  output logic      out_disable,
  output logic      sync_in
);
  int   cnt_ff = 0;
  logic sq_ff  = 1'b0;
  // Peer clock at 250 kHz, on the pin only while the device listens
  always @(posedge sys_clk) begin
    cnt_ff <= (cnt_ff == HALF - 1) ? 0 : cnt_ff + 1;
    if (cnt_ff == HALF - 1) sq_ff <= ~sq_ff;
  end
  assign sync_in = sync_oe ? sync_out : sq_ff;
  // Alarm fed back into the disable pin, ORed with the host request
  assign out_disable = ext_mute | (loop_en & short_alarm);
endmodule
`default_nettype wire

// [verification/acps_sequencer_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module acps_sequencer_tb_top;
  import acps_pkg::*;
  localparam int SC = 20;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        sys_clk, rst_n, clk_en, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, pwr_off_n, out_disable, timing_role_select;
  logic        sync_in, sync_out, sync_oe, bias_ref_ok, short_det, temp_trip, temp_cooled;
  logic        out_enable, low_power, short_alarm, switch_clk, irq, loop_en, ext_mute;
  int          failures, check_count, cyc, n;
  logic [41:0] rows [7] = '{{OFS_CTRL, 32'h0, RESP_OKAY}, {OFS_IRQ_ENABLE, 32'h0, RESP_OKAY},
    {OFS_OSC_HALF, 16'h0, OSC_HALF_RST, RESP_OKAY}, {OFS_IRQ_CLEAR, 32'h0, RESP_OKAY},
    {OFS_STATUS, (32'h1 << ST_LOW_PWR), RESP_OKAY}, {OFS_IRQ_STATUS, 32'h0, RESP_OKAY},
    {8'h1c, 32'h0, RESP_SLVERR}};
  acps_sequencer #(.STARTUP_CYC(SC)) dut_u (.sys_clk, .rst_n, .clk_en, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pwr_off_n, .out_disable,
    .timing_role_select, .sync_in, .sync_out, .sync_oe, .bias_ref_ok, .short_det, .temp_trip,
    .temp_cooled, .out_enable, .low_power, .short_alarm, .switch_clk, .irq);
  acps_ctl_model model_u (.sys_clk, .loop_en, .ext_mute, .short_alarm, .sync_oe, .sync_out,
    .out_disable, .sync_in);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_t, w_t, b_t;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge sys_clk);
      aw_t = s_axi_awvalid & s_axi_awready;
      w_t = s_axi_wvalid & s_axi_wready;
      b_t = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge sys_clk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end while (!b_t);
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_t, r_t;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge sys_clk);
      ar_t = s_axi_arvalid & s_axi_arready;
      r_t = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge sys_clk);
      if (ar_t) s_axi_arvalid <= 1'b0;
    end while (!r_t);
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    axi_rd(a, rd, rs);
    chk(rd, d);
    chk(rs, r);
  endtask
  // Checks low_power, out_enable, short_alarm and irq after w cycles
  task automatic pins(input int w, input logic [3:0] e);
    repeat (w) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({low_power, out_enable, short_alarm, irq}, e);
    @(posedge sys_clk);
  endtask
  task automatic wait_oe(input int lo, input int hi);
    int k;
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
    end while (out_enable !== 1'b1 && k < 500);
    chk(k >= lo && k <= hi, 1'b1);
    @(posedge sys_clk);
  endtask
  task automatic count_tog(input int len, input logic sel, output int t);
    logic v, p;
    t = 0;
    p = sel ? switch_clk : short_alarm;
    repeat (len) begin
      @(negedge sys_clk);
      v = sel ? switch_clk : short_alarm;
      if (v !== p) t++;
      p = v;
    end
    @(posedge sys_clk);
  endtask
  task automatic power_up;
    pwr_off_n <= 1'b1;
    pins(10, 4'b0000);
    bias_ref_ok <= 1'b1;
    wait_oe(SC, SC + 3);
  endtask
  initial begin
    failures = 0;
    check_count = 0;
    {rst_n, pwr_off_n, bias_ref_ok, short_det, temp_trip, loop_en, ext_mute} = 7'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {clk_en, temp_cooled, timing_role_select} = 3'h6;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0, 32'h0, 4'hf};
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    foreach (rows[i]) rdchk(rows[i][41:34], rows[i][33:2], rows[i][1:0]);
    axi_wr(OFS_STATUS, 32'h1, rs);
    chk(rs, RESP_SLVERR);
    $display("test registers done");
    power_up();
    rdchk(OFS_IRQ_STATUS, 32'h1 << IRQ_RUN, RESP_OKAY);
    pwr_off_n <= 1'b0;
    bias_ref_ok <= 1'b0;
    pins(6, 4'b1000);
    power_up();
    ext_mute <= 1'b1;
    pins(6, 4'b0000);
    ext_mute <= 1'b0;
    wait_oe(2, 5);
    axi_wr(OFS_CTRL, 32'h1, rs);
    pins(3, 4'b0000);
    axi_wr(OFS_CTRL, 32'h0, rs);
    wait_oe(1, 4);
    $display("test start-up and mute done");
    axi_wr(OFS_IRQ_ENABLE, 32'h1 << IRQ_SHORT, rs);
    short_det <= 1'b1;
    @(posedge sys_clk);
    short_det <= 1'b0;
    pins(10, 4'b0011);
    ext_mute <= 1'b1;
    pins(6, 4'b0001);
    ext_mute <= 1'b0;
    wait_oe(2, 5);
    axi_wr(OFS_IRQ_CLEAR, 32'h1 << IRQ_SHORT, rs);
    pins(1, 4'b0100);
    axi_wr(OFS_IRQ_ENABLE, 32'h0, rs);
    loop_en <= 1'b1;
    short_det <= 1'b1;
    count_tog(100, 1'b0, n);
    chk(n >= 4, 1'b1);
    short_det <= 1'b0;
    pins(30, 4'b0100);
    axi_rd(OFS_IRQ_STATUS, rd, rs);
    chk(rd[IRQ_SHORT], 1'b1);
    $display("test short protection done");
    {temp_cooled, temp_trip} <= 2'h1;
    @(posedge sys_clk);
    temp_trip <= 1'b0;
    pins(40, 4'b1000);
    temp_cooled <= 1'b1;
    wait_oe(SC, SC + 6);
    rdchk(OFS_IRQ_STATUS, 32'hf, RESP_OKAY);
    $display("test thermal done");
    {clk_en, pwr_off_n, bias_ref_ok} <= 3'h0;
    pins(6, 4'b0100);
    clk_en <= 1'b1;
    pins(6, 4'b1000);
    power_up();
    $display("test clock enable done");
    count_tog(800, 1'b1, n);
    chk(n >= 3 && n <= 5 && !sync_oe, 1'b1);
    rdchk(OFS_SYNC_PERIOD, 32'h190, RESP_OKAY);
    axi_wr(OFS_OSC_HALF, 32'h10, rs);
    timing_role_select <= 1'b1;
    repeat (6) @(posedge sys_clk);
    count_tog(320, 1'b1, n);
    chk(n >= 19 && n <= 21 && sync_oe, 1'b1);
    chk(sync_out, switch_clk);
    $display("test timing role done");
    rst_n <= 1'b0;
    pins(2, 4'b1000);
    rst_n <= 1'b1;
    rdchk(OFS_OSC_HALF, {16'h0, OSC_HALF_RST}, RESP_OKAY);
    wait_oe(SC, SC + 6);
    $display("test reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
